// ===== src/phy_control_status_regs.sv
// phy control and 10 Mb/s status/control register bank
//
// Function
// RL1: sequence select bit picks 15-stage pattern when set, 9-stage when clear
// RL2: self-test result read only, 1 pass, latched, cleared by start-bit write
// RL3: start bit runs the test until cleared; software runs it at least 1 ms
// RL4: led stretch bypass shows raw status on the leds
// RL5: pause flag reads 1 only when both ends advertise pause, resets 0
// RL6: five-bit management address in low bits, resets to all ones
// RL7: 10 Mb/s loopback bit is ORed with the basic mode loopback bit
// RL8: link pulse off bit, ORed with external force, stops link pulses
// RL9: force good link bit ORed with external force forces good 10 Mb/s link
// RL10: polarity force bit forces inverted receive polarity
// RL11: polarity status latches high, cleared by reading either copy
// RL12: auto-polarity off bit stops automatic polarity sensing and correction
// RL13: software always writes one into bit 2 of the 10 Mb/s register
// RL14: heartbeat off acts only at 10 Mb/s half duplex, else heartbeat off
// RL15: jabber off bit acts only at 10 Mb/s full duplex
// RL16: software performs the five-write setup sequence for one revision
// RL17: registers sit at i/o base plus offset
// RL18: reserved bits read zero and ignore writes, bit 2 excepted
`timescale 1ns/1ps
module phy_control_status_regs import phy_regs_pkg::*; #(
  parameter int SELFTEST_MIN_CYCLES = SELFTEST_MIN_CYC,
  parameter int LED_STRETCH_CYCLES  = LED_STRETCH_CYC
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               reset_n,
  // register access, offset already stripped of the i/o base
  input  wire reg_req_t           req,
  output logic [15:0]             rdata_q,
  output logic                    rvalid_q,
  // line status from the transceiver
  input  wire line_status_t       line,
  input  wire logic               polarity_event,
  input  wire logic               phy_status_read,
  // leds
  input  wire logic [LED_N-1:0]   led_raw,
  output logic [LED_N-1:0]        led_out_q,
  // self-test pattern
  input  wire logic               selftest_rx,
  output logic                    selftest_tx_q,
  // controls toward the datapath
  output tenbase_ctl_t            ctl_q,
  output logic [4:0]              mgmt_port_address_q,
  output logic                    polarity_flag_q,
  output analog_cfg_t             cfg_q
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // stored fields
  logic [15:0] page_q;
  logic        long_seq_q;
  logic        run_q;
  logic        led_byp_q;
  logic        pause_q;
  logic [8:0]  tb_q;
  logic        pol_q;

  // decode
  logic        test_page;
  logic        wr_page, wr_pc, wr_pmd, wr_tb, wr_dsp, wr_sd, wr_tdat;
  logic        rd_tb;
  logic [15:0] pc_view, tb_view, rd_mux;
  logic [8:0]  tb_wmask;
  logic        result;
  logic        tx_bit;
  logic        pol_d;
  tenbase_ctl_t ctl_d;
  logic [LED_N-1:0] stretched;

  // the 0xe4 slot is shared: the test page swaps in the pmd register
  assign test_page = page_q == PAGE_TEST;
  assign wr_page = req.wr && hit(req.addr, OFS_PAGE_SEL); // RL17
  assign wr_pc   = req.wr && hit(req.addr, OFS_PHY_CTRL) && !test_page;
  assign wr_pmd  = req.wr && hit(req.addr, OFS_PHY_CTRL) && test_page;
  assign wr_tb   = req.wr && hit(req.addr, OFS_TENBASE);
  assign wr_dsp  = req.wr && hit(req.addr, OFS_DSP_CFG);
  assign wr_sd   = req.wr && hit(req.addr, OFS_SD_CFG);
  assign wr_tdat = req.wr && hit(req.addr, OFS_TEST_DATA);
  assign rd_tb   = req.rd && hit(req.addr, OFS_TENBASE);

  // the polarity bit is status only, so it is masked out of writes
  assign tb_wmask = 9'h1ef; // RL18

  assign pc_view = {4'h0, long_seq_q, result, run_q, led_byp_q, pause_q,
                    2'b00, mgmt_port_address_q}; // RL18
  assign tb_view = {7'h00, tb_q[TB_LOOP:TB_INV], pol_q,
                    tb_q[TB_APOL_OFF:0]}; // RL18

  assign rd_mux =
      hit(req.addr, OFS_PAGE_SEL)  ? page_q :
      hit(req.addr, OFS_PHY_CTRL)  ? (test_page ? cfg_q.pmd : pc_view) :
      hit(req.addr, OFS_TENBASE)   ? tb_view :
      hit(req.addr, OFS_DSP_CFG)   ? cfg_q.dsp :
      hit(req.addr, OFS_SD_CFG)    ? cfg_q.sd :
      hit(req.addr, OFS_TEST_DATA) ? cfg_q.tdat : 16'h0000;

  // set wins over a clear in the same cycle so no event is lost
  assign pol_d = polarity_event
               | (pol_q & !(rd_tb | phy_status_read)); // RL11

  // the 10 Mb/s duplex qualifiers are taken from live line status
  assign ctl_d.slow_loopback_en = tb_q[TB_LOOP] | line.basic_mode_ctrl_reg_loopback; // RL7
  assign ctl_d.link_pulse_off =
      tb_q[TB_LP_OFF] | line.ext_slow_link_force; // RL8
  assign ctl_d.link_good_force =
      tb_q[TB_FORCE] | line.ext_slow_link_force; // RL9
  assign ctl_d.invert_polarity_force = tb_q[TB_INV]; // RL10
  assign ctl_d.auto_polarity_off = tb_q[TB_APOL_OFF]; // RL12
  assign ctl_d.sqe_test_en = !line.speed_100 && !line.full_duplex
                           && !tb_q[TB_SQE_OFF]; // RL14
  assign ctl_d.babble_guard_en =
      (!line.speed_100 && line.full_duplex) ? !tb_q[TB_BAB_OFF] : 1'b1; // RL15

  selftest_prbs #(
    .MIN_CYCLES (SELFTEST_MIN_CYCLES)
  ) u_selftest (
    .clock    (clock),
    .reset_n  (reset_n),
    .run      (run_q),
    .long_seq (long_seq_q),
    .start_wr (wr_pc),
    .rx_bit   (selftest_rx),
    .tx_bit   (tx_bit),
    .result   (result)
  );

  // register writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      page_q              <= CFG_RST;
      long_seq_q          <= PHY_CTRL_RST[PC_LONG_SEQ];
      run_q               <= PHY_CTRL_RST[PC_RUN];
      led_byp_q           <= PHY_CTRL_RST[PC_LED_BYP];
      mgmt_port_address_q <= PHY_CTRL_RST[PC_ADDR_HI:0];
    end else begin
      if (wr_page)
        page_q <= req.wdata;
      if (wr_pc) begin
        long_seq_q          <= req.wdata[PC_LONG_SEQ]; // RL1
        run_q               <= req.wdata[PC_RUN]; // RL3
        led_byp_q           <= req.wdata[PC_LED_BYP];
        mgmt_port_address_q <= req.wdata[PC_ADDR_HI:0]; // RL6
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tb_q  <= TENBASE_RST[8:0];
      cfg_q <= {4{CFG_RST}};
    end else begin
      if (wr_tb)
        tb_q <= req.wdata[8:0] & tb_wmask; // RL18
      if (wr_pmd)
        cfg_q.pmd <= req.wdata;
      if (wr_dsp)
        cfg_q.dsp <= req.wdata;
      if (wr_sd)
        cfg_q.sd <= req.wdata;
      if (wr_tdat)
        cfg_q.tdat <= req.wdata;
    end
  end

  // status and derived controls
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pause_q         <= PHY_CTRL_RST[PC_PAUSE];
      pol_q           <= TENBASE_RST[TB_POL];
      polarity_flag_q <= TENBASE_RST[TB_POL];
      ctl_q           <= '0;
      selftest_tx_q   <= 1'b0;
    end else begin
      pause_q         <= line.local_pause & line.partner_pause; // RL5
      pol_q           <= pol_d; // RL11
      polarity_flag_q <= pol_d; // RL11
      ctl_q           <= ctl_d;
      selftest_tx_q   <= tx_bit;
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd)
        rdata_q <= rd_mux;
    end
  end

  // led stretching: a raw pulse reloads its hold counter
  genvar i;
  generate
    for (i = 0; i < LED_N; i++) begin : g_led
      logic [CNT_W-1:0] hold_q;
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n)
          hold_q <= '0;
        else if (led_raw[i])
          hold_q <= CNT_W'(LED_STRETCH_CYCLES);
        else if (hold_q != '0)
          hold_q <= hold_q - CNT_W'(1);
      end
      assign stretched[i] = led_raw[i] | (hold_q != '0);
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      led_out_q <= '0;
    else
      led_out_q <= led_byp_q ? led_raw : stretched; // RL4
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_led_byp;
    led_byp_q |=> led_out_q == $past(led_raw);
  endproperty
  a_led_byp: assert property (p_led_byp) // RL4
    else $error("led bypass not showing raw value");
  property p_pause;
    ##1 pause_q == $past(line.local_pause && line.partner_pause);
  endproperty
  a_pause: assert property (p_pause) // RL5
    else $error("pause flag does not match both ends");
  property p_addr;
    wr_pc ##1 !wr_pc |-> mgmt_port_address_q == $past(req.wdata[4:0]);
  endproperty
  a_addr: assert property (p_addr) // RL6
    else $error("management address not stored");
  property p_loop;
    ##1 ctl_q.slow_loopback_en == $past(tb_q[TB_LOOP] | line.basic_mode_ctrl_reg_loopback);
  endproperty
  a_loop: assert property (p_loop) // RL7
    else $error("loopback not ORed");
  property p_force;
    line.ext_slow_link_force |=>
      ctl_q.link_good_force && ctl_q.link_pulse_off;
  endproperty
  a_force: assert property (p_force) // RL9
    else $error("external force ignored");
  property p_pol_set;
    polarity_event |=> pol_q ##1 (pol_q || $past(rd_tb || phy_status_read));
  endproperty
  a_pol_set: assert property (p_pol_set) // RL11
    else $error("polarity status lost");
  property p_pol_clr;
    (rd_tb || phy_status_read) && !polarity_event |=> !pol_q;
  endproperty
  a_pol_clr: assert property (p_pol_clr) // RL11
    else $error("polarity status not cleared by read");
  property p_sqe;
    line.speed_100 || line.full_duplex |=> !ctl_q.sqe_test_en;
  endproperty
  a_sqe: assert property (p_sqe) // RL14
    else $error("heartbeat enabled outside 10 Mb/s half duplex");
  property p_babble;
    !(!line.speed_100 && line.full_duplex) |=> ctl_q.babble_guard_en;
  endproperty
  a_babble: assert property (p_babble) // RL15
    else $error("jabber off outside 10 Mb/s full duplex");
  property p_resv;
    req.rd && hit(req.addr, OFS_TENBASE) |=> rdata_q[15:9] == 7'h00;
  endproperty
  a_resv: assert property (p_resv) // RL18
    else $error("unused bits read non-zero");
  // field-level checks on the controls and the read views
  property p_lp_off;
    ##1 ctl_q.link_pulse_off ==
        $past(tb_q[TB_LP_OFF] | line.ext_slow_link_force);
  endproperty
  a_lp_off: assert property (p_lp_off) // RL8
    else $error("link pulse off not ORed with external force");
  property p_good;
    ##1 ctl_q.link_good_force ==
        $past(tb_q[TB_FORCE] | line.ext_slow_link_force);
  endproperty
  a_good: assert property (p_good) // RL9
    else $error("forced good link not ORed");
  property p_inv;
    ##1 ctl_q.invert_polarity_force == $past(tb_q[TB_INV]);
  endproperty
  a_inv: assert property (p_inv) // RL10
    else $error("polarity force not applied");
  property p_apol;
    ##1 ctl_q.auto_polarity_off == $past(tb_q[TB_APOL_OFF]);
  endproperty
  a_apol: assert property (p_apol) // RL12
    else $error("auto polarity off not applied");
  property p_rvalid;
    ##1 rvalid_q == $past(req.rd);
  endproperty
  a_rvalid: assert property (p_rvalid) // RL17
    else $error("read answer not one cycle after strobe");
  property p_run;
    wr_pc |=> run_q == $past(req.wdata[PC_RUN])
          && long_seq_q == $past(req.wdata[PC_LONG_SEQ]);
  endproperty
  a_run: assert property (p_run) // RL3
    else $error("start or sequence select not stored");
  property p_page;
    wr_pmd |=> cfg_q.pmd == $past(req.wdata)
           && mgmt_port_address_q == $past(mgmt_port_address_q);
  endproperty
  a_page: assert property (p_page) // RL17
    else $error("test page write reached the wrong register");
  property p_tb_wr;
    wr_tb |=> tb_q[8:5] == $past(req.wdata[8:5])
          && tb_q[3:0] == $past(req.wdata[3:0]) && !tb_q[TB_POL];
  endproperty
  a_tb_wr: assert property (p_tb_wr) // RL18
    else $error("10 Mb/s register write not stored as masked");
  property p_pol_rd;
    rd_tb |=> rdata_q[TB_POL] == $past(pol_q);
  endproperty
  a_pol_rd: assert property (p_pol_rd) // RL11
    else $error("polarity status not shown in the 10 Mb/s view");
  property p_pc_resv;
    req.rd && hit(req.addr, OFS_PHY_CTRL) && !test_page |=>
      rdata_q[15:12] == 4'h0 && rdata_q[6:5] == 2'b00;
  endproperty
  a_pc_resv: assert property (p_pc_resv) // RL18
    else $error("phy control reserved bits read non-zero");
  property p_pause_rd;
    req.rd && hit(req.addr, OFS_PHY_CTRL) && !test_page |=>
      rdata_q[PC_PAUSE] == $past(pause_q);
  endproperty
  a_pause_rd: assert property (p_pause_rd) // RL5
    else $error("pause flag not shown in the phy control view");
  property p_result_rd;
    req.rd && hit(req.addr, OFS_PHY_CTRL) && !test_page |=>
      rdata_q[PC_RESULT] == $past(result);
  endproperty
  a_result_rd: assert property (p_result_rd) // RL2
    else $error("self-test result not shown in the phy control view");

  c_page: cover property (wr_page ##1 wr_pmd);
  c_pol: cover property (polarity_event ##[1:4] rd_tb);
  c_run: cover property (wr_pc && req.wdata[PC_RUN]);
  c_byp: cover property (led_byp_q && led_raw != '0);
endmodule // phy_control_status_regs

// ===== src/phy_regs_pkg.sv
// package: register map, field layout and timing of the phy control bank
package phy_regs_pkg;
  // register offsets from the i/o base
  localparam logic [7:0] OFS_PAGE_SEL  = 8'hcc;
  localparam logic [7:0] OFS_PHY_CTRL  = 8'he4;
  localparam logic [7:0] OFS_TENBASE   = 8'he8;
  localparam logic [7:0] OFS_DSP_CFG   = 8'hf4;
  localparam logic [7:0] OFS_SD_CFG    = 8'hf8;
  localparam logic [7:0] OFS_TEST_DATA = 8'hfc;
  localparam logic [15:0] PAGE_TEST    = 16'h0001;
  // phy control fields
  localparam int PC_LONG_SEQ = 11;
  localparam int PC_RESULT   = 10;
  localparam int PC_RUN      = 9;
  localparam int PC_LED_BYP  = 8;
  localparam int PC_PAUSE    = 7;
  localparam int PC_ADDR_HI  = 4;
  // 10 Mb/s status and control fields
  localparam int TB_LOOP     = 8;
  localparam int TB_LP_OFF   = 7;
  localparam int TB_FORCE    = 6;
  localparam int TB_INV      = 5;
  localparam int TB_POL      = 4;
  localparam int TB_APOL_OFF = 3;
  localparam int TB_ONE      = 2;
  localparam int TB_SQE_OFF  = 1;
  localparam int TB_BAB_OFF  = 0;
  // reset values
  localparam logic [15:0] PHY_CTRL_RST = 16'h003f;
  localparam logic [15:0] TENBASE_RST  = 16'h0004;
  localparam logic [15:0] CFG_RST      = 16'h0000;
  // timing
  localparam int CLOCK_MHZ        = 50;
  localparam int SELFTEST_MIN_US  = 1000;
  localparam int SELFTEST_MIN_CYC = SELFTEST_MIN_US * CLOCK_MHZ;
  localparam int LED_STRETCH_US   = 42000;
  localparam int LED_STRETCH_CYC  = LED_STRETCH_US * CLOCK_MHZ;
  localparam int CNT_W            = 22;
  localparam logic [3:0] WARM_BITS = 4'hf;
  localparam int LED_N            = 3;

  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic basic_mode_ctrl_reg_loopback;
    logic ext_slow_link_force;
    logic local_pause;
    logic partner_pause;
    logic speed_100;
    logic full_duplex;
  } line_status_t;

  typedef struct packed {
    logic slow_loopback_en;
    logic link_pulse_off;
    logic link_good_force;
    logic invert_polarity_force;
    logic auto_polarity_off;
    logic sqe_test_en;
    logic babble_guard_en;
  } tenbase_ctl_t;

  typedef struct packed {
    logic [15:0] pmd;
    logic [15:0] dsp;
    logic [15:0] sd;
    logic [15:0] tdat;
  } analog_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WARM  = 3'b010,
    ST_CHECK = 3'b100
  } selftest_state_t;
endpackage

// ===== src/selftest_prbs.sv
// self-test pattern generator and checker with latched result
`timescale 1ns/1ps
module selftest_prbs import phy_regs_pkg::*; #(
  parameter int MIN_CYCLES = SELFTEST_MIN_CYC
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // control
  input  wire logic run,
  input  wire logic long_seq,
  input  wire logic start_wr,
  // pattern
  input  wire logic rx_bit,
  output logic      tx_bit,
  output logic      result
);
  selftest_state_t  state_q, state_d;
  logic [14:0]      gen_q, chk_q;
  logic [3:0]       warm_q;
  logic [CNT_W-1:0] cnt_q;
  logic             err_q, gen_fb, chk_fb, mismatch, min_done;

  assign gen_fb   = long_seq ? gen_q[14] ^ gen_q[13] : gen_q[8] ^ gen_q[4]; // RL1
  assign chk_fb   = long_seq ? chk_q[14] ^ chk_q[13] : chk_q[8] ^ chk_q[4]; // RL1
  assign mismatch = (state_q == ST_CHECK) && (rx_bit != chk_fb);
  assign min_done = cnt_q >= CNT_W'(MIN_CYCLES - 1);
  assign tx_bit   = gen_q[0];

  always_comb begin
    case (state_q)
      ST_IDLE:  state_d = run ? ST_WARM : ST_IDLE; // RL3
      // a start write re-warms the checker, so a sequence change made
      // while running is not counted as a fail
      ST_WARM:  state_d = !run ? ST_IDLE
                        : (warm_q == WARM_BITS && !start_wr) ? ST_CHECK
                        : ST_WARM;
      ST_CHECK: state_d = !run ? ST_IDLE
                        : start_wr ? ST_WARM : ST_CHECK; // RL2 RL3
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      gen_q   <= '1;
      chk_q   <= '0;
      warm_q  <= '0;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      gen_q   <= run ? {gen_q[13:0], gen_fb} : '1;
      chk_q   <= {chk_q[13:0], rx_bit};
      warm_q  <= (state_q == ST_WARM && !start_wr) ? warm_q + 4'h1 : 4'h0;
      cnt_q   <= (state_q != ST_CHECK) ? '0
               : min_done ? cnt_q : cnt_q + CNT_W'(1);
    end
  end

  // a fail is latched until software rewrites the start bit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      err_q  <= 1'b0;
      result <= 1'b0;
    end else if (start_wr) begin
      err_q  <= 1'b0; // RL2
      result <= 1'b0; // RL2
    end else begin
      err_q  <= err_q | mismatch;
      if (mismatch)
        result <= 1'b0; // RL2
      else if (state_q == ST_CHECK && min_done && !err_q)
        result <= 1'b1; // RL2
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_seq_len;
    run && $past(run) |=> gen_q[0] == $past(gen_fb);
  endproperty
  a_seq_len: assert property (p_seq_len) // RL1
    else $error("pattern generator feedback wrong");
  property p_result_clear;
    start_wr |=> !result;
  endproperty
  a_result_clear: assert property (p_result_clear) // RL2
    else $error("result not cleared by start write");
  property p_run_stop;
    !run |=> state_q == ST_IDLE;
  endproperty
  a_run_stop: assert property (p_run_stop) // RL3
    else $error("self test did not stop");
  property p_rewarm;
    start_wr && run |=> state_q == ST_WARM;
  endproperty
  a_rewarm: assert property (p_rewarm) // RL2
    else $error("start write did not restart the checker");
  c_pass: cover property (!result ##1 result);
endmodule // selftest_prbs

// ===== bench/test_phy_control_status_regs.sv
// self-checking testbench for the phy control register bank
`timescale 1ns/1ps
module test_phy_control_status_regs import phy_regs_pkg::*;;
  localparam int ST_CYC  = 20;
  localparam int LED_CYC = 8;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } reg_row_t;

  typedef struct packed {
    logic [15:0]  tb;
    line_status_t ln;
    logic [6:0]   exp;
  } ctl_row_t;

  logic             clock;
  logic             reset_n;
  reg_req_t         req;
  logic [15:0]      rdata_q;
  logic             rvalid_q;
  line_status_t     line;
  logic             polarity_event;
  logic             phy_status_read;
  logic [LED_N-1:0] led_raw;
  logic [LED_N-1:0] led_out_q;
  logic             selftest_rx;
  logic             selftest_tx_q;
  logic             rx_invert;
  logic [15:0]      hist;
  tenbase_ctl_t     ctl_q;
  logic [4:0]       mgmt_port_address_q;
  logic             polarity_flag_q;
  analog_cfg_t      cfg_q;
  int               fail_count;
  int               check_count;
  int               i;

  reg_row_t rows [11] = '{
    '{8'he4, 16'hffff, 16'h0b1f},
    '{8'he4, 16'h0000, 16'h0000},
    '{8'he8, 16'hffff, 16'h01ef},
    '{8'he8, 16'hfe14, 16'h0004},
    '{8'he8, 16'h0004, 16'h0004},
    '{8'hf4, 16'h5a5a, 16'h5a5a},
    '{8'hf8, 16'ha5a5, 16'ha5a5},
    '{8'hfc, 16'h1234, 16'h1234},
    '{8'hcc, 16'h0000, 16'h0000},
    '{8'h10, 16'hffff, 16'h0000},
    '{8'he4, 16'h001f, 16'h001f}
  };

  // line order: loopback, ext force, local pause, partner pause, 100, fdx
  ctl_row_t crows [10] = '{
    '{16'h0006, 6'b000000, 7'h01},
    '{16'h0004, 6'b000010, 7'h01},
    '{16'h0004, 6'b000001, 7'h01},
    '{16'h0005, 6'b000001, 7'h00},
    '{16'h0005, 6'b000000, 7'h03},
    '{16'h0005, 6'b000011, 7'h01},
    '{16'h0004, 6'b010000, 7'h33},
    '{16'h0004, 6'b100000, 7'h43},
    '{16'h01ec, 6'b000000, 7'h7f},
    '{16'h0004, 6'b000000, 7'h03}
  };

  phy_control_status_regs #(
    .SELFTEST_MIN_CYCLES (ST_CYC),
    .LED_STRETCH_CYCLES  (LED_CYC)
  ) u_dut (
    .clock               (clock),
    .reset_n             (reset_n),
    .req                 (req),
    .rdata_q             (rdata_q),
    .rvalid_q            (rvalid_q),
    .line                (line),
    .polarity_event      (polarity_event),
    .phy_status_read     (phy_status_read),
    .led_raw             (led_raw),
    .led_out_q           (led_out_q),
    .selftest_rx         (selftest_rx),
    .selftest_tx_q       (selftest_tx_q),
    .ctl_q               (ctl_q),
    .mgmt_port_address_q (mgmt_port_address_q),
    .polarity_flag_q     (polarity_flag_q),
    .cfg_q               (cfg_q)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // loop the pattern back; the inverter lets a scenario inject errors
  always @(posedge clock) begin
    if (!reset_n) begin
      selftest_rx <= 1'b0;
      hist <= '0;
    end else begin
      selftest_rx <= selftest_tx_q ^ rx_invert;
      hist <= {hist[14:0], selftest_tx_q};
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e,
                      input string nm);
    int n;
    @(posedge clock);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    n = 0;
    while (rvalid_q !== 1'b1) begin
      n++;
      if (n > 3) begin
        chk("rvalid", 16'h0000, 16'h0001);
        end_of_test();
      end
      waitc(1);
    end
    chk(nm, rdata_q, e);
  endtask

  task automatic pulse(input logic ev, input logic sr);
    @(posedge clock);
    polarity_event <= ev;
    phy_status_read <= sr;
    @(posedge clock);
    polarity_event <= 1'b0;
    phy_status_read <= 1'b0;
    #1;
  endtask

  // the loop must follow one lfsr recurrence (either tap order) and not
  // sit at all zeros, which would satisfy any recurrence trivially
  task automatic seq_chk(input logic lng, input string nm);
    int ba;
    int bb;
    int ones;
    int ln;
    ba = 0;
    bb = 0;
    ones = 0;
    ln = lng ? 15 : 9;
    repeat (40) begin
      waitc(1);
      ba += int'(hist[0] !== (hist[ln] ^ hist[lng ? 14 : 5]));
      bb += int'(hist[0] !== (hist[ln] ^ hist[lng ? 1 : 4]));
      ones += int'(hist[0] === 1'b1);
    end
    chk(nm, 16'((ba == 0 || bb == 0) && ones > 0), 16'h0001);
  endtask

  initial begin
    reset_n = 1'b0;
    req = '0;
    line = '0;
    polarity_event = 1'b0;
    phy_status_read = 1'b0;
    led_raw = '0;
    rx_invert = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    chk("addr", 16'(mgmt_port_address_q), 16'h001f);
    rchk(8'he4, 16'h001f, "phy_rst");
    rchk(8'he8, 16'h0004, "tb_rst");
    for (i = 0; i < 11; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rchk(rows[i].addr, rows[i].exp, $sformatf("row%0d", i));
    end
    for (i = 0; i < 10; i++) begin
      @(posedge clock);
      line <= crows[i].ln;
      wr(8'he8, crows[i].tb);
      waitc(3);
      chk($sformatf("ctl%0d", i), 16'(ctl_q), 16'(crows[i].exp));
    end
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      line.local_pause <= i[1];
      line.partner_pause <= i[0];
      waitc(2);
      rchk(8'he4, (i == 3) ? 16'h009f : 16'h001f, "pause");
    end
    @(posedge clock);
    line <= '0;
    pulse(1'b1, 1'b0);
    chk("pol", 16'(polarity_flag_q), 16'h0001);
    rchk(8'he8, 16'h0014, "pol_rd");
    waitc(1);
    chk("pol_clr", 16'(polarity_flag_q), 16'h0000);
    rchk(8'he8, 16'h0004, "pol_rd0");
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    rchk(8'he8, 16'h0004, "pol_sts");
    pulse(1'b1, 1'b1);
    chk("pol_both", 16'(polarity_flag_q), 16'h0001);
    pulse(1'b0, 1'b1);
    chk("pol_sts2", 16'(polarity_flag_q), 16'h0000);
    for (i = 0; i < 2; i++) begin
      wr(8'he4, i[0] ? 16'h0a1f : 16'h021f);
      rchk(8'he4, i[0] ? 16'h0a1f : 16'h021f, "st_clr");
      seq_chk(i[0], "st_seq");
      waitc(ST_CYC + 40);
      rchk(8'he4, i[0] ? 16'h0e1f : 16'h061f, "st_pass");
    end
    rx_invert <= 1'b1;
    waitc(10);
    rx_invert <= 1'b0;
    waitc(ST_CYC + 40);
    rchk(8'he4, 16'h0a1f, "st_fail");
    wr(8'he4, 16'h001f);
    rchk(8'he4, 16'h001f, "st_stop");
    wr(8'he4, 16'h011f);
    @(posedge clock);
    led_raw <= 3'b101;
    waitc(2);
    chk("led_byp", 16'(led_out_q), 16'h0005);
    led_raw <= 3'b000;
    waitc(2);
    chk("led_raw0", 16'(led_out_q), 16'h0000);
    wr(8'he4, 16'h001f);
    @(posedge clock);
    led_raw <= 3'b010;
    @(posedge clock);
    led_raw <= 3'b000;
    waitc(3);
    chk("led_str", 16'(led_out_q), 16'h0002);
    waitc(LED_CYC + 4);
    chk("led_off", 16'(led_out_q), 16'h0000);
    // revision setup sequence, in its required order
    wr(8'hcc, 16'h0001);
    wr(8'he4, 16'h189c);
    wr(8'hfc, 16'h0000);
    wr(8'hf4, 16'h5040);
    wr(8'hf8, 16'h008c);
    waitc(2);
    chk("pmd", cfg_q.pmd, 16'h189c);
    chk("dsp", cfg_q.dsp, 16'h5040);
    chk("sd", cfg_q.sd, 16'h008c);
    chk("tdat", cfg_q.tdat, 16'h0000);
    rchk(8'he4, 16'h189c, "pmd_rd");
    wr(8'hcc, 16'h0000);
    rchk(8'he4, 16'h001f, "phy_back");
    wr(8'he4, 16'h0a05);
    @(posedge clock);
    reset_n <= 1'b0;
    waitc(2);
    chk("addr_rst2", 16'(mgmt_port_address_q), 16'h001f);
    reset_n <= 1'b1;
    rchk(8'he4, 16'h001f, "phy_rst2");
    end_of_test();
  end
endmodule // test_phy_control_status_regs
